// ==== common/tmc_pkg.sv ====
/*
  Package for the second timer's control and status block: addresses,
  field positions, reset value, divider counts and the bus request struct.
  Assumes a byte-wide special-function bus with byte and bit writes.
*/
package tmc_pkg;
  // Control register address and reset value
  localparam logic [7:0] TMC_CTRL_ADDR = 8'hc8;
  localparam logic [7:0] TMC_CTRL_RESET = 8'h00;
  // Field positions inside the control register
  localparam int TMC_B_HOF = 7;
  localparam int TMC_B_LOF = 6;
  localparam int TMC_B_LIE = 5;
  localparam int TMC_B_CAP = 4;
  localparam int TMC_B_SPLIT = 3;
  localparam int TMC_B_RUN = 2;
  localparam int TMC_B_UNUSED = 1;
  localparam int TMC_B_XCLK = 0;
  // Writable bits; the unused bit is held at zero
  localparam logic [7:0] TMC_WR_MASK = 8'hfd;
  // Clock dividers: core clock by 12, external oscillator by 8
  localparam int TMC_DIV_CORE = 12;
  localparam int TMC_DIV_EXT = 8;
  // Byte roll point
  localparam logic [7:0] TMC_BYTE_MAX = 8'hff;

  // One special-function bus request
  typedef struct packed {
    logic [7:0] addr;    // Register address
    logic wr;            // Byte write strobe
    logic rd;            // Read strobe
    logic [7:0] wdata;   // Byte write data
    logic bit_wr;        // Single-bit write strobe
    logic [2:0] bit_idx; // Bit position for bit write
    logic bit_val;       // Value for bit write
  } tmc_req_t;
endpackage

// ==== design/tmc_timer2.sv ====
/*
  Second timer: control register, 16-bit or split 8-bit counter with
  auto-reload, clock selection, comparator capture and interrupt request.
  Assumes the bus request and reload bytes come from logic on ref_clk, and
  that the external oscillator and comparator output are asynchronous pins.
*/
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - High byte rollover sets high overflow flag
// - High flag with irq enable requests interrupt
// - Low byte rollover always sets low flag
// - Flags cleared only by software writes
// - Low byte irq enable adds low overflow interrupt
// - Comparator rising edge copies count to capture value in 16-bit mode
// - Capture event also interrupts when enabled
// - Split bit selects 16-bit or two bytes
// - Run gates counter; split gates high only
// - Bit one reads zero, ignores writes
// - External select: core/12 or oscillator/8
// - External select covers both split bytes
// - Control register at 0xc8, bit-addressable
// - 16-bit wrap loads reload pair
// - Each split byte reloads from own byte
// - Per-byte select forces core clock
// - Interrupt enable is external enable bit
module tmc_timer2
  import tmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire tmc_req_t req,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] reload_high_byte,
  input wire logic [7:0] reload_low_byte,
  input wire logic high_byte_core_clock_select,
  input wire logic low_byte_core_clock_select,
  input wire logic timer_irq_enable,
  input wire logic ext_osc,
  input wire logic capture_compare_input,
  output logic [15:0] count,
  output logic capture_load,
  output logic [15:0] capture_value,
  output logic timer_irq
);

  logic [7:0] timer2_control;       // Control and status register
  logic [7:0] next_timer2_control;
  logic [7:0] next_rdata;
  logic [15:0] next_count;
  logic next_capture_load;
  logic [15:0] next_capture_value;
  logic [3:0] div12;                // Core clock prescaler
  logic [3:0] next_div12;
  logic [2:0] div8;                 // External edge prescaler
  logic [2:0] next_div8;
  logic [2:0] osc_sync;             // Three-stage synchroniser
  logic [2:0] cmp_sync;
  logic osc_stable;                 // Last agreed oscillator level
  logic cmp_stable;
  logic next_osc_stable;
  logic next_cmp_stable;
  logic osc_rise;
  logic cmp_rise;
  logic tick12;
  logic tick8;
  logic lo_tick;
  logic hi_tick;
  logic lo_ovf;                     // Low byte rolls this cycle
  logic hi_ovf;                     // High byte rolls this cycle
  logic cap_evt;
  logic ctrl_hit;

  // Field shorthands
  wire logic split = timer2_control[TMC_B_SPLIT];
  wire logic run = timer2_control[TMC_B_RUN];
  wire logic xclk = timer2_control[TMC_B_XCLK];

  // Source tick for one byte: core clock, or external choice
  function automatic logic byte_tick(input logic sys_sel, input logic t12,
                                     input logic t8, input logic xsel);
    byte_tick = sys_sel ? 1'b1 : (xsel ? t8 : t12);
  endfunction

  // Synchronisers register only; stages two and three are compared below
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_sync <= 3'h0;
      cmp_sync <= 3'h0;
    end else if (ce) begin
      osc_sync <= {osc_sync[1:0], ext_osc};
      cmp_sync <= {cmp_sync[1:0], capture_compare_input};
    end
  end

  // Edge qualification: a level counts once stages two and three agree
  always_comb begin
    next_osc_stable = osc_stable;
    next_cmp_stable = cmp_stable;
    if (osc_sync[1] == osc_sync[2]) begin
      next_osc_stable = osc_sync[2];
    end
    if (cmp_sync[1] == cmp_sync[2]) begin
      next_cmp_stable = cmp_sync[2];
    end
    osc_rise = next_osc_stable & ~osc_stable;
    cmp_rise = next_cmp_stable & ~cmp_stable;
  end

  // Prescalers; a tick is one core cycle wide
  always_comb begin
    tick12 = (div12 == 4'(TMC_DIV_CORE - 1));
    next_div12 = tick12 ? 4'h0 : div12 + 4'h1;
    tick8 = osc_rise && (div8 == 3'(TMC_DIV_EXT - 1));
    next_div8 = osc_rise ? div8 + 3'h1 : div8; // Wraps at eight
    lo_tick = byte_tick(low_byte_core_clock_select, tick12, tick8, xclk);
    hi_tick = byte_tick(high_byte_core_clock_select, tick12, tick8, xclk);
  end

  // Counter: one 16-bit or two 8-bit auto-reload counters
  always_comb begin
    next_count = count;
    lo_ovf = 1'b0;
    hi_ovf = 1'b0;
    if (!split) begin
      // Whole counter steps on the low byte's clock choice
      if (run && lo_tick) begin
        lo_ovf = (count[7:0] == TMC_BYTE_MAX);
        hi_ovf = (count == 16'hffff);
        if (hi_ovf) begin
          next_count = {reload_high_byte, reload_low_byte};
        end else begin
          next_count = count + 16'h0001;
        end
      end
    end else begin
      // Low byte ignores run in split mode
      if (lo_tick) begin
        lo_ovf = (count[7:0] == TMC_BYTE_MAX);
        next_count[7:0] = lo_ovf ? reload_low_byte : count[7:0] + 8'h01;
      end
      if (run && hi_tick) begin
        hi_ovf = (count[15:8] == TMC_BYTE_MAX);
        next_count[15:8] = hi_ovf ? reload_high_byte : count[15:8] + 8'h01;
      end
    end
  end

  // Capture only in 16-bit mode with capture enabled
  always_comb begin
    cap_evt = cmp_rise && timer2_control[TMC_B_CAP] && !split;
    next_capture_load = cap_evt;
    next_capture_value = cap_evt ? count : capture_value;
  end

  // Control register: byte and bit writes, then hardware sets on top
  always_comb begin
    ctrl_hit = (req.addr == TMC_CTRL_ADDR);
    next_timer2_control = timer2_control;
    if (ctrl_hit && req.wr) begin
      next_timer2_control = req.wdata & TMC_WR_MASK;
    end else if (ctrl_hit && req.bit_wr) begin
      next_timer2_control[req.bit_idx] = req.bit_val;
      next_timer2_control[TMC_B_UNUSED] = 1'b0;
    end
    // Sets applied last so an overflow is never lost to a clear
    if (hi_ovf || cap_evt) begin
      next_timer2_control[TMC_B_HOF] = 1'b1;
    end
    if (lo_ovf) begin
      next_timer2_control[TMC_B_LOF] = 1'b1;
    end
    // Read data registered; other addresses read zero
    next_rdata = sfr_rdata;
    if (req.rd) begin
      next_rdata = ctrl_hit ? timer2_control : 8'h00;
    end
  end

  // State registers, frozen while ce is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer2_control <= TMC_CTRL_RESET;
      sfr_rdata <= 8'h00;
      count <= 16'h0000;
      div12 <= 4'h0;
      div8 <= 3'h0;
      osc_stable <= 1'b0;
      cmp_stable <= 1'b0;
      capture_load <= 1'b0;
      capture_value <= 16'h0000;
    end else if (ce) begin
      timer2_control <= next_timer2_control;
      sfr_rdata <= next_rdata;
      count <= next_count;
      div12 <= next_div12;
      div8 <= next_div8;
      osc_stable <= next_osc_stable;
      cmp_stable <= next_cmp_stable;
      capture_load <= next_capture_load;
      capture_value <= next_capture_value;
    end
  end

  // Level request; stays up until software clears the flag
  always_comb begin
    timer_irq = timer_irq_enable &&
                (timer2_control[TMC_B_HOF] ||
                 (timer2_control[TMC_B_LIE] && timer2_control[TMC_B_LOF]));
  end

  // Checks
  logic sw_clr_hof;
  logic sw_clr_lof;
  always_comb begin
    sw_clr_hof = ctrl_hit && ((req.wr && !req.wdata[TMC_B_HOF]) ||
                 (req.bit_wr && req.bit_idx == 3'h7 && !req.bit_val));
    sw_clr_lof = ctrl_hit && ((req.wr && !req.wdata[TMC_B_LOF]) ||
                 (req.bit_wr && req.bit_idx == 3'h6 && !req.bit_val));
  end

  a_hof_set: assert property (@(posedge ref_clk) disable iff (rst)
    ce && hi_ovf |=> timer2_control[TMC_B_HOF])
    else $error("high flag not set on overflow");
  a_irq_high: assert property (@(posedge ref_clk) disable iff (rst)
    timer_irq_enable && timer2_control[TMC_B_HOF] |-> timer_irq)
    else $error("no interrupt for high flag");
  a_lof_set: assert property (@(posedge ref_clk) disable iff (rst)
    ce && lo_ovf |=> timer2_control[TMC_B_LOF])
    else $error("low flag not set on overflow");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (rst)
    timer2_control[TMC_B_HOF] && !(ce && sw_clr_hof) |=> timer2_control[TMC_B_HOF])
    else $error("high flag cleared by hardware");
  a_irq_low: assert property (@(posedge ref_clk) disable iff (rst)
    !timer_irq_enable || (!timer2_control[TMC_B_HOF] &&
    !(timer2_control[TMC_B_LIE] && timer2_control[TMC_B_LOF])) |-> !timer_irq)
    else $error("spurious interrupt");
  a_cap_copy: assert property (@(posedge ref_clk) disable iff (rst)
    ce && cap_evt |=> capture_load && capture_value == $past(count))
    else $error("capture value wrong");
  a_cap_flag: assert property (@(posedge ref_clk) disable iff (rst)
    ce && cap_evt |=> timer2_control[TMC_B_HOF])
    else $error("capture did not set flag");
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
    ce && req.rd |=> sfr_rdata[TMC_B_UNUSED] == 1'b0)
    else $error("unused bit read as one");
  a_reload_16: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !split && hi_ovf |=> count == {$past(reload_high_byte), $past(reload_low_byte)})
    else $error("16-bit reload wrong");
  a_split_low: assert property (@(posedge ref_clk) disable iff (rst)
    ce && split && !run && lo_tick |=> count[15:8] == $past(count[15:8]))
    else $error("high byte ran while stopped");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    ce && lo_ovf && sw_clr_lof |=> timer2_control[TMC_B_LOF])
    else $error("clear beat overflow");

  c_wrap16: cover property (@(posedge ref_clk) disable iff (rst) ce && !split && hi_ovf);
  c_split_lo: cover property (@(posedge ref_clk) disable iff (rst) ce && split && lo_ovf);
  c_capture: cover property (@(posedge ref_clk) disable iff (rst) ce && cap_evt);
  c_race: cover property (@(posedge ref_clk) disable iff (rst) ce && hi_ovf && sw_clr_hof);
  c_split_hi: cover property (@(posedge ref_clk) disable iff (rst) ce && split && hi_ovf);

  // Low flag obeys the same hold rule as the high flag
  a_lof_hold: assert property (@(posedge ref_clk) disable iff (rst)
    timer2_control[TMC_B_LOF] && !(ce && sw_clr_lof) |=> timer2_control[TMC_B_LOF])
    else $error("low flag cleared by hardware");

  // Register shape: the unused bit never holds a one
  a_unused_reg: assert property (@(posedge ref_clk) disable iff (rst)
    timer2_control[TMC_B_UNUSED] == 1'b0)
    else $error("unused bit stored");

  // Capture is meaningless on split bytes, so it must stay silent there
  a_no_split_cap: assert property (@(posedge ref_clk) disable iff (rst)
    split |-> !cap_evt)
    else $error("capture in split mode");

  // A stopped 16-bit counter keeps its value
  a_stop_16: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !split && !run |=> count == $past(count))
    else $error("counter moved while stopped");

  // Split bytes reload from their own reload byte
  a_split_lo_rl: assert property (@(posedge ref_clk) disable iff (rst)
    ce && split && lo_ovf |=> count[7:0] == $past(reload_low_byte))
    else $error("low byte reload wrong");
  a_split_hi_rl: assert property (@(posedge ref_clk) disable iff (rst)
    ce && split && hi_ovf |=> count[15:8] == $past(reload_high_byte))
    else $error("high byte reload wrong");

  // Read of the control address returns the register as it stood
  a_read_ctrl: assert property (@(posedge ref_clk) disable iff (rst)
    ce && req.rd && ctrl_hit |=> sfr_rdata == $past(timer2_control))
    else $error("control read wrong");

  // Tick choice: core clock select wins, else the external choice
  a_sys_tick: assert property (@(posedge ref_clk) disable iff (rst)
    low_byte_core_clock_select |-> lo_tick)
    else $error("core clock select ignored");
  a_ext_tick: assert property (@(posedge ref_clk) disable iff (rst)
    !low_byte_core_clock_select && xclk |-> lo_tick == tick8)
    else $error("external tick choice wrong");

endmodule
`default_nettype wire

// ==== tb/tmc_timer2_tb_top.sv ====
/*
  Self-checking bench for the second timer block: register access, dividers,
  overflow flags and reload, split mode, interrupt request and capture.
  Assumes the package and the design module are compiled beforehand.
*/
`timescale 1ns/10ps
`default_nettype none
module tmc_timer2_tb_top;
  import tmc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  tmc_req_t req = '0;
  logic [7:0] sfr_rdata;
  logic [7:0] rl_hi = 8'h00; // Reload pair from outside
  logic [7:0] rl_lo = 8'h00;
  logic hi_sel = 1'b0; // Per-byte core clock selects
  logic lo_sel = 1'b0;
  logic irq_en = 1'b0;
  logic ext_osc = 1'b0;
  logic cmp_in = 1'b0;
  logic [15:0] count;
  logic capture_load;
  logic [15:0] capture_value;
  logic timer_irq;
  logic [15:0] snap; // Count snapshot for rate checks
  int num_errors = 0;
  int n_checks = 0;
  int k;

  // 25 MHz core clock
  always #20 ref_clk = ~ref_clk;

  tmc_timer2 tmc_timer2_i (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .req(req), .sfr_rdata(sfr_rdata),
    .reload_high_byte(rl_hi), .reload_low_byte(rl_lo),
    .high_byte_core_clock_select(hi_sel), .low_byte_core_clock_select(lo_sel),
    .timer_irq_enable(irq_en), .ext_osc(ext_osc), .capture_compare_input(cmp_in),
    .count(count), .capture_load(capture_load), .capture_value(capture_value),
    .timer_irq(timer_irq)
  );

  // Verdict and end of run
  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compare with case inequality so unknowns fail
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Byte write: strobe held one edge, released after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  // Single-bit write to the control register
  task automatic bw(input logic [2:0] i, input logic v);
    @(posedge ref_clk);
    req.addr <= TMC_CTRL_ADDR;
    req.bit_idx <= i;
    req.bit_val <= v;
    req.bit_wr <= 1'b1;
    @(posedge ref_clk);
    req.bit_wr <= 1'b0;
  endtask

  // Read; data lands on the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk(name, {8'h00, exp}, {8'h00, sfr_rdata});
  endtask

  // Bounded wait for a count value; running out ends the run
  task automatic wait_cnt(input logic [15:0] v, input int lim);
    for (k = 0; k < lim; k++) begin
      @(posedge ref_clk);
      #1;
      if (count === v) return;
    end
    num_errors++;
    stop_test();
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(TMC_CTRL_ADDR, TMC_CTRL_RESET, "reset value");
    rd(8'hc9, 8'h00, "other address");
    wr(TMC_CTRL_ADDR, 8'hff);
    rd(TMC_CTRL_ADDR, 8'hfd, "all ones");
    wr(TMC_CTRL_ADDR, 8'h00);
    bw(3'd1, 1'b1);
    bw(3'd2, 1'b1);
    rd(TMC_CTRL_ADDR, 8'h04, "bit writes");
    // Core clock by 12: exactly two steps in 24 cycles
    snap = count;
    repeat (24) @(posedge ref_clk);
    #1;
    chk("core div", snap + 16'd2, count);
    // External by 8: 32 oscillator rises, sync phase allows one step slack
    bw(3'd0, 1'b1);
    #1;
    snap = count;
    repeat (64) begin
      repeat (2) @(posedge ref_clk);
      ext_osc <= ~ext_osc;
    end
    #1;
    chk("ext div", 16'd1, {15'd0, (count - snap) inside {[16'd3:16'd5]}});
    // Full 16-bit wrap on core clock
    rl_hi <= 8'hff;
    rl_lo <= 8'hf0;
    lo_sel <= 1'b1;
    wr(TMC_CTRL_ADDR, 8'h04);
    wait_cnt(16'hffff, 70000);
    @(posedge ref_clk);
    #1;
    chk("wrap reload", 16'hfff0, count);
    chk("irq masked", 16'd0, {15'd0, timer_irq});
    rd(TMC_CTRL_ADDR, 8'hc4, "both flags");
    @(posedge ref_clk);
    irq_en <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("irq high flag", 16'd1, {15'd0, timer_irq});
    // Flags stay with counting stopped until software clears them
    bw(3'd2, 1'b0);
    repeat (40) @(posedge ref_clk);
    rd(TMC_CTRL_ADDR, 8'hc0, "flags kept");
    bw(3'd7, 1'b0);
    rd(TMC_CTRL_ADDR, 8'h40, "high cleared");
    bw(3'd6, 1'b0);
    // Split, run off: low byte still counts, high byte holds
    #1;
    snap = count;
    wr(TMC_CTRL_ADDR, 8'h08);
    repeat (300) @(posedge ref_clk);
    rd(TMC_CTRL_ADDR, 8'h48, "split low flag");
    chk("high held", {8'h00, snap[15:8]}, {8'h00, count[15:8]});
    chk("low reload", 16'd1, {15'd0, count[7:0] >= 8'hf0});
    chk("low irq off", 16'd0, {15'd0, timer_irq});
    bw(3'd5, 1'b1);
    #1;
    chk("low irq on", 16'd1, {15'd0, timer_irq});
    // Capture with counting stopped so the copied value is exact
    wr(TMC_CTRL_ADDR, 8'h10);
    bw(3'd6, 1'b0);
    @(posedge ref_clk);
    cmp_in <= 1'b1;
    for (k = 0; k < 10 && capture_load !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("capture pulse", 16'd1, {15'd0, capture_load});
    chk("capture value", count, capture_value);
    chk("capture irq", 16'd1, {15'd0, timer_irq});
    @(posedge ref_clk);
    #1;
    chk("pulse ends", 16'd0, {15'd0, capture_load});
    cmp_in <= 1'b0;
    rd(TMC_CTRL_ADDR, 8'h90, "capture flag");
    stop_test();
  end
endmodule
`default_nettype wire
